// [hdl/dctd_top.sv]
// dctd_top: 8-bit and 16-bit down-counter/timers with edge capture,
// APB register slave, timer-driven pin muxes and interrupt requests.
// assumes: all inputs synchronous to i_clk; interrupt requests go to an
// external controller.
//
// Operation
// - narrow timer runs only while enabled; writing one to enable starts it
// - narrow transmit: reload-mode zero reloads at terminal count, one stops there
// - narrow timeout flag set at terminal count unless a selected edge comes that cycle, cleared by writing one
// - first narrow count tick after enable may come early, partial period
// - narrow capture mask set: interrupt request on every edge capture
// - narrow counter mask set: interrupt request on timeout
// - control bit picks port data or narrow timer output for pin a
// - wide clock select picks system clock divided by 1, 2, 4 or 8
// - wide capture mask set: interrupt request on each wide capture
// - wide counter mask set: interrupt request on wide timeout
// - wide clock select, capture mask and pin select reset to zero
// - wide timer runs only while its enable holds one
// - wide transmit: reload-mode zero reloads, one stops at terminal count
// - wide capture mode: zero acts on every edge, one on first only
// - wide timeout flag set at terminal count, cleared by writing one
// - stop and status clear take effect one counter tick later
// - narrow capture mode starts counting at first selected edge
// - later edges store complemented count: rise low, fall high register
// - after capture set edge flag, maybe interrupt, reload all ones
// - narrow count reaching zero before next edge sets timeout flag
`timescale 1ns/1ps

module dctd_top
  import dctd_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  input  wire logic              i_demod_in,
  input  wire logic              i_port_a_data,
  input  wire logic              i_port_b_data,
  output logic                   o_timer_pin_a,
  output logic                   o_timer_pin_b,
  output logic                   o_narrow_irq,
  output logic                   o_wide_irq
);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 6 || ADDR_W > 32)
  begin : g_bad_addr
    $error("dctd_top: ADDR_W must lie in 6..32");
  end

  // ==========================================================
  // helpers
  // prescaler tick: divide by 1, 2, 4 or 8 off a free-running counter
  function automatic logic presc_tick(input logic [1:0] sel, input logic [2:0] cnt);
    logic [2:0] mask;
    mask = 3'((4'h1 << sel) - 4'h1);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic [7:0] ctl_read(input logic [7:0] ctl, input logic flag);
    logic [7:0] v;
    v         = ctl;
    v[CTL_TO] = flag;
    return v;
  endfunction

  dctd_st_t s;
  dctd_st_t n;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic                ntick;
    logic                wtick;
    logic                rise;
    logic                fall;
    logic                qedge;
    logic                acc;
    logic                map_ok;
    logic [ADDR_W-3:0]   idx;
    logic [7:0]          wb;
    logic [7:0]          rd;
    ntick  = 1'b0;
    wtick  = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    qedge  = 1'b0;
    acc    = 1'b0;
    map_ok = 1'b0;
    idx    = i_paddr[ADDR_W-1:2];
    wb     = i_pwdata[7:0];
    rd     = 8'h00;
    n      = s;
    n.n_irq = 1'b0;
    n.w_irq = 1'b0;

    // free prescaler, so the first tick after enable lands anywhere
    n.presc = s.presc + 3'h1;
    ntick = presc_tick(s.nctl[CTL_CLK_HI:CTL_CLK_LO], s.presc);
    wtick = presc_tick(s.wctl[CTL_CLK_HI:CTL_CLK_LO], s.presc);

    n.edge_prev = i_demod_in;
    rise  = i_demod_in & ~s.edge_prev & s.sctl[SH_ESEL_LO];
    fall  = ~i_demod_in & s.edge_prev & s.sctl[SH_ESEL_HI];
    qedge = rise | fall;

    // ========================================================
    // narrow timer
    if (s.sctl[SH_NDEMOD])
    begin
      unique case (s.n_state)
        NST_IDLE:
        begin
          n.n_state = NST_IDLE;
        end
        NST_WAIT:
        begin
          if (qedge)
          begin
            n.n_state = NST_COUNT;
            n.n_cnt   = s.n_init_lo;
          end
        end
        NST_COUNT:
        begin
          if (qedge)
          begin
            if (rise)
            begin
              n.n_cap_r = ~s.n_cnt;
            end
            else
            begin
              n.n_cap_f = ~s.n_cnt;
            end
            n.n_irq = s.nctl[CTL_CAPM];
            n.n_cnt = NARROW_RELOAD;
          end
          else if (ntick)
          begin
            if (s.n_cnt == 8'h00)
            begin
              n.n_state = NST_WAIT;
              n.n_irq   = s.nctl[CTL_CNTM];
            end
            else
            begin
              n.n_cnt = s.n_cnt - 8'h01;
            end
          end
        end
        default:
        begin
          n.n_state = NST_IDLE;
        end
      endcase
    end
    else if (s.n_state != NST_IDLE && ntick)
    begin
      if (s.n_cnt == 8'h00)
      begin
        n.n_irq = s.nctl[CTL_CNTM];
        n.n_out = ~s.n_out;
        n.n_cnt = s.n_out ? s.n_init_lo : s.n_init_hi;
        if (s.nctl[CTL_SINGLE])
        begin
          n.n_state      = NST_IDLE;
          n.nctl[CTL_EN] = 1'b0;
        end
      end
      else
      begin
        n.n_cnt = s.n_cnt - 8'h01;
      end
    end

    // ========================================================
    // wide timer
    if (s.w_run && s.sctl[SH_WDEMOD] && qedge && !(s.wctl[CTL_SINGLE] && s.w_done))
    begin
      {n.w_cap_hi, n.w_cap_lo} = ~s.w_cnt;
      n.w_cnt  = {s.w_init_hi, s.w_init_lo};
      n.w_done = 1'b1;
      n.w_irq  = s.wctl[CTL_CAPM];
    end
    else if (s.w_run && wtick)
    begin
      if (s.w_cnt == 16'h0000)
      begin
        n.w_irq = s.wctl[CTL_CNTM];
        n.w_out = ~s.w_out;
        n.w_cnt = {s.w_init_hi, s.w_init_lo};
        if (s.wctl[CTL_SINGLE])
        begin
          n.w_run        = 1'b0;
          n.wctl[CTL_EN] = 1'b0;
        end
      end
      else
      begin
        n.w_cnt = s.w_cnt - 16'h0001;
      end
    end

    // ========================================================
    // status flags: pending clears wait for a tick, a set always wins
    // deferred stop and clear
    if (ntick)
    begin
      n.n_to_clr = 1'b0;
      n.rise_clr = 1'b0;
      n.fall_clr = 1'b0;
      if (s.n_stop)
      begin
        n.n_stop  = 1'b0;
        n.n_state = NST_IDLE;
      end
    end
    if (wtick)
    begin
      n.w_to_clr = 1'b0;
      if (s.w_stop)
      begin
        n.w_stop = 1'b0;
        n.w_run  = 1'b0;
      end
    end
    n.n_to   = (s.n_to & ~(s.n_to_clr & ntick))
             | (ntick & s.n_cnt == 8'h00 & !qedge
                & (s.n_state == NST_COUNT | (s.n_state == NST_WAIT & !s.sctl[SH_NDEMOD])));
    n.rise_f = (s.rise_f & ~(s.rise_clr & ntick))
             | (s.sctl[SH_NDEMOD] & s.n_state == NST_COUNT & rise);
    n.fall_f = (s.fall_f & ~(s.fall_clr & ntick))
             | (s.sctl[SH_NDEMOD] & s.n_state == NST_COUNT & fall);
    n.w_to   = (s.w_to & ~(s.w_to_clr & wtick))
             | (s.w_run & wtick & s.w_cnt == 16'h0000
                & !(s.sctl[SH_WDEMOD] & qedge & !(s.wctl[CTL_SINGLE] & s.w_done)));

    // ========================================================
    // APB slave: read data latched in setup, answer in access
    map_ok = (idx <= (ADDR_W-2)'(IDX_LAST));
    unique case (idx)
      (ADDR_W-2)'(IDX_NARROW_CTRL):    rd = ctl_read(s.nctl, s.n_to);
      (ADDR_W-2)'(IDX_SHARED_CTRL):    rd = {s.sctl[7:2], s.rise_f, s.fall_f};
      (ADDR_W-2)'(IDX_WIDE_CTRL):      rd = ctl_read(s.wctl, s.w_to);
      (ADDR_W-2)'(IDX_NARROW_INIT_LO): rd = s.n_init_lo;
      (ADDR_W-2)'(IDX_NARROW_INIT_HI): rd = s.n_init_hi;
      (ADDR_W-2)'(IDX_NARROW_CAP_R):   rd = s.n_cap_r;
      (ADDR_W-2)'(IDX_NARROW_CAP_F):   rd = s.n_cap_f;
      (ADDR_W-2)'(IDX_WIDE_INIT_LO):   rd = s.w_init_lo;
      (ADDR_W-2)'(IDX_WIDE_INIT_HI):   rd = s.w_init_hi;
      (ADDR_W-2)'(IDX_WIDE_CAP_LO):    rd = s.w_cap_lo;
      (ADDR_W-2)'(IDX_WIDE_CAP_HI):    rd = s.w_cap_hi;
      default:                         rd = 8'h00;
    endcase

    if (!i_psel)
    begin
      n.rd_valid = 1'b0;
    end
    else if (!s.rd_valid)
    begin
      n.rd_valid = 1'b1;
      n.prdata   = {24'h00_0000, rd};
      n.pslverr  = !map_ok;
    end

    acc = i_psel & i_penable & s.rd_valid;
    if (acc)
    begin
      n.rd_valid = 1'b0;
    end

    if (acc && i_pwrite && map_ok && i_pstrb[0])
    begin
      unique case (idx)
        (ADDR_W-2)'(IDX_NARROW_CTRL):
        begin
          n.nctl         = wb;
          n.nctl[CTL_TO] = 1'b0;
          // live flags written back as one get cleared
          if (wb[CTL_TO])
          begin
            n.n_to_clr = 1'b1;
          end
          if (wb[CTL_EN])
          begin
            n.n_stop  = 1'b0;
            n.n_out   = 1'b0;
            n.n_cnt   = s.n_init_lo;
            n.n_state = s.sctl[SH_NDEMOD] ? NST_WAIT : NST_COUNT;
          end
          else if (s.n_state != NST_IDLE)
          begin
            n.n_stop = 1'b1;
          end
        end
        (ADDR_W-2)'(IDX_SHARED_CTRL):
        begin
          n.sctl          = wb;
          n.sctl[SH_RISE] = 1'b0;
          n.sctl[SH_FALL] = 1'b0;
          if (wb[SH_RISE])
          begin
            n.rise_clr = 1'b1;
          end
          if (wb[SH_FALL])
          begin
            n.fall_clr = 1'b1;
          end
        end
        (ADDR_W-2)'(IDX_WIDE_CTRL):
        begin
          n.wctl         = wb;
          n.wctl[CTL_TO] = 1'b0;
          if (wb[CTL_TO])
          begin
            n.w_to_clr = 1'b1;
          end
          if (wb[CTL_EN])
          begin
            n.w_stop = 1'b0;
            n.w_run  = 1'b1;
            n.w_done = 1'b0;
            n.w_out  = 1'b0;
            n.w_cnt  = {s.w_init_hi, s.w_init_lo};
          end
          else if (s.w_run)
          begin
            n.w_stop = 1'b1;
          end
        end
        (ADDR_W-2)'(IDX_NARROW_INIT_LO): n.n_init_lo = wb;
        (ADDR_W-2)'(IDX_NARROW_INIT_HI): n.n_init_hi = wb;
        (ADDR_W-2)'(IDX_WIDE_INIT_LO):   n.w_init_lo = wb;
        (ADDR_W-2)'(IDX_WIDE_INIT_HI):   n.w_init_hi = wb;
        default:
        begin
          n.presc = s.presc + 3'h1;
        end
      endcase
    end

    // ========================================================
    // pin muxes
    // pin a source
    n.pin_a = s.nctl[CTL_PIN] ? s.n_out : i_port_a_data;
    n.pin_b = s.wctl[CTL_PIN] ? s.w_out : i_port_b_data;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s <= ST_RESET;
    end
    else if (i_ce)
    begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs
  assign o_pready      = i_psel & i_penable & s.rd_valid & i_ce;
  assign o_prdata      = s.prdata;
  assign o_pslverr     = s.pslverr;
  assign o_timer_pin_a = s.pin_a;
  assign o_timer_pin_b = s.pin_b;
  assign o_narrow_irq  = s.n_irq;
  assign o_wide_irq    = s.w_irq;

endmodule

// [inc/dctd_pkg.sv]
// dctd_pkg: register indices, field positions, reset values and state
// types of the dual counter/timer with edge capture.
// assumes: 32-bit APB slave, byte address = 4 * register index.
package dctd_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam int unsigned IDX_NARROW_CTRL    = 0;
  localparam int unsigned IDX_SHARED_CTRL    = 1;
  localparam int unsigned IDX_WIDE_CTRL      = 2;
  localparam int unsigned IDX_NARROW_INIT_LO = 3;
  localparam int unsigned IDX_NARROW_INIT_HI = 4;
  localparam int unsigned IDX_NARROW_CAP_R   = 5;
  localparam int unsigned IDX_NARROW_CAP_F   = 6;
  localparam int unsigned IDX_WIDE_INIT_LO   = 7;
  localparam int unsigned IDX_WIDE_INIT_HI   = 8;
  localparam int unsigned IDX_WIDE_CAP_LO    = 9;
  localparam int unsigned IDX_WIDE_CAP_HI    = 10;
  localparam int unsigned IDX_LAST           = 10;

  // ==========================================================
  // narrow and wide timer control fields
  localparam int unsigned CTL_EN     = 7;
  localparam int unsigned CTL_SINGLE = 6;
  localparam int unsigned CTL_TO     = 5;
  localparam int unsigned CTL_CLK_HI = 4;
  localparam int unsigned CTL_CLK_LO = 3;
  localparam int unsigned CTL_CAPM   = 2;
  localparam int unsigned CTL_CNTM   = 1;
  localparam int unsigned CTL_PIN    = 0;

  // ==========================================================
  // shared control fields
  localparam int unsigned SH_NDEMOD  = 7;
  localparam int unsigned SH_WDEMOD  = 6;
  localparam int unsigned SH_ESEL_HI = 5;
  localparam int unsigned SH_ESEL_LO = 4;
  localparam int unsigned SH_RISE    = 1;
  localparam int unsigned SH_FALL    = 0;

  // ==========================================================
  // reset and reload values
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  NARROW_RELOAD = 8'hFF;
  localparam logic [2:0]  PRESC_RESET   = 3'h0;

  // ==========================================================
  // narrow timer sequencing
  typedef enum logic [1:0] {
    NST_IDLE  = 2'b00,
    NST_WAIT  = 2'b01,
    NST_COUNT = 2'b10
  } dctd_nstate_t;

  typedef struct packed {
    logic [7:0]   nctl;
    logic [7:0]   wctl;
    logic [7:0]   sctl;
    logic         n_to;
    logic         w_to;
    logic         rise_f;
    logic         fall_f;
    logic         n_to_clr;
    logic         w_to_clr;
    logic         rise_clr;
    logic         fall_clr;
    logic         n_stop;
    logic         w_stop;
    dctd_nstate_t n_state;
    logic         w_run;
    logic         w_done;
    logic [7:0]   n_cnt;
    logic [15:0]  w_cnt;
    logic [7:0]   n_init_lo;
    logic [7:0]   n_init_hi;
    logic [7:0]   n_cap_r;
    logic [7:0]   n_cap_f;
    logic [7:0]   w_init_lo;
    logic [7:0]   w_init_hi;
    logic [7:0]   w_cap_lo;
    logic [7:0]   w_cap_hi;
    logic         n_out;
    logic         w_out;
    logic [2:0]   presc;
    logic         edge_prev;
    logic         rd_valid;
    logic [31:0]  prdata;
    logic         pslverr;
    logic         n_irq;
    logic         w_irq;
    logic         pin_a;
    logic         pin_b;
  } dctd_st_t;

  localparam dctd_st_t ST_RESET = '0;

endpackage

// [verif/dctd_top_props.sv]
// dctd_top_props: port-level checks of the timer block's apb slave and reset.
// assumes: bound into dctd_top; one clock, synchronous active-high reset.
`timescale 1ns/1ps

module dctd_top_props
  import dctd_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire logic              i_ce,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic              o_pready,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pslverr,
  input wire logic              o_timer_pin_a,
  input wire logic              o_timer_pin_b,
  input wire logic              o_narrow_irq,
  input wire logic              o_wide_irq
);
  // ==========================================================
  // setup cycle as the slave takes it
  logic setup;
  logic unmapped;
  assign setup    = i_psel && !i_penable && i_ce;
  assign unmapped = i_paddr[ADDR_W-1:2] > IDX_LAST;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // ==========================================================
  // bus handshake and read data
  AST_PREADY_ZWS:
    assert property (setup ##1 (i_psel && i_penable && i_ce) |-> o_pready)
    else $error("pready low in first access cycle");
  AST_PREADY_QUAL:
    assert property (o_pready |-> i_psel && i_penable && i_ce)
    else $error("pready outside an access cycle");
  AST_ERR_UNMAPPED:
    assert property ((setup && unmapped) ##1 o_pready |-> o_pslverr)
    else $error("no error on unmapped index");
  AST_ZERO_UNMAPPED:
    assert property ((setup && unmapped) ##1 o_pready |-> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OK_MAPPED:
    assert property ((setup && !unmapped) ##1 o_pready |-> !o_pslverr && o_prdata[31:8] == 24'h00_0000)
    else $error("mapped access flagged or upper bytes set");
  // read data only moves at a taken setup edge
  AST_RDATA_HOLD:
    assert property (!setup |=> $stable(o_prdata) && $stable(o_pslverr))
    else $error("read data moved without a setup");
  AST_CE_FREEZE:
    assert property (!i_ce |=> $stable({o_narrow_irq, o_wide_irq, o_timer_pin_a, o_timer_pin_b}))
    else $error("outputs moved with clock enable low");
  AST_RESET_OUT:
    assert property (disable iff (1'b0) i_srst |=> !o_narrow_irq && !o_wide_irq && !o_pslverr
      && !o_timer_pin_a && !o_timer_pin_b && o_prdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");

  cover property (o_narrow_irq);
  cover property (o_wide_irq);
  cover property (o_pready && o_pslverr);
endmodule

bind dctd_top dctd_top_props #(.ADDR_W(ADDR_W)) i_dctd_top_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_timer_pin_a(o_timer_pin_a), .o_timer_pin_b(o_timer_pin_b),
  .o_narrow_irq(o_narrow_irq), .o_wide_irq(o_wide_irq)
);

// [verif/testbench.sv]
// testbench: directed register, timer and edge-capture scenarios for dctd_top.
// assumes: the checker binds itself; the bench plays apb master and port side.
`timescale 1ns/1ps

module testbench
  import dctd_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0]  i_pstrb = 4'h0;
  logic        i_demod_in = 1'b0;
  logic        i_port_a_data = 1'b0;
  logic        i_port_b_data = 1'b0;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic        o_timer_pin_a;
  logic        o_timer_pin_b;
  logic        o_narrow_irq;
  logic        o_wide_irq;
  logic [7:0]  rv;
  logic        re;
  int          err_count = 0;
  int          n_tests = 0;
  int          g;
  int          p;
  int          l;

  dctd_top i_dctd_top (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_demod_in(i_demod_in),
    .i_port_a_data(i_port_a_data), .i_port_b_data(i_port_b_data), .o_timer_pin_a(o_timer_pin_a),
    .o_timer_pin_b(o_timer_pin_b), .o_narrow_irq(o_narrow_irq), .o_wide_irq(o_wide_irq)
  );

  always #4 i_clk = ~i_clk;

  // ==========================================================
  // closing, compares and bus cycles
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // x in got must fail, so test the range result against one
  task automatic chk_in(input string nm, input int lo, input int hi, input logic [15:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= {24'h00_0000, d};
    i_pstrb   <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1);
    chk_in("pready wait", 1, 1, n[15:0]);
    rv = o_prdata[7:0];
    re = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00, 4'h1);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // cycles from one irq pulse to the next, capped at lim
  task automatic gap(input bit w, input int lim, output int c);
    c = 0;
    // no cap here: a dead timer must end in the watchdog
    do
    begin
      @(posedge i_clk);
    end
    while ((w ? o_wide_irq : o_narrow_irq) !== 1'b1);
    do
    begin
      @(posedge i_clk);
      c++;
    end
    while ((w ? o_wide_irq : o_narrow_irq) !== 1'b1 && c < lim);
  endtask

  task automatic watch(input bit w, input int k, output int np, output int nl);
    np = 0;
    nl = 0;
    repeat (k)
    begin
      @(posedge i_clk);
      // unknowns count against the check
      np += ((w ? o_wide_irq : o_narrow_irq) !== 1'b0);
      nl += ((w ? o_timer_pin_b : o_timer_pin_a) !== 1'b1);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    i_ce <= 1'b0;
    idle(4);
    i_ce <= 1'b1;
    rd(8'h00);
    chk("narrow ctrl reset", CTRL_RESET, rv);
    rd(8'h04);
    chk("shared ctrl reset", CTRL_RESET, rv);
    rd(8'h08);
    chk("wide ctrl reset", CTRL_RESET, rv);
    apb(1'b1, 8'h0C, 8'h5A, 4'h0);
    rd(8'h0C);
    chk("strobe off write", 8'h00, rv);
    rd(8'h2C);
    chk("unmapped error", 8'h01, {7'h00, re});
  endtask

  task automatic t_narrow();
    i_port_a_data <= 1'b1;
    wr(8'h0C, 8'h03);
    wr(8'h10, 8'h03);
    wr(8'h00, 8'h83);
    gap(1'b0, 200, g);
    chk_in("narrow period", 4, 4, g[15:0]);
    watch(1'b0, 16, p, l);
    chk_in("narrow irq count", 4, 4, p[15:0]);
    chk_in("pin a timer lows", 8, 8, l[15:0]);
    i_ce <= 1'b0;
    watch(1'b0, 6, p, l);
    chk_in("frozen irq count", 0, 0, p[15:0]);
    i_ce <= 1'b1;
    rd(8'h00);
    chk("narrow flag set", 8'hA3, rv);
    wr(8'h00, 8'h01);
    idle(8);
    wr(8'h00, 8'h20);
    idle(4);
    watch(1'b0, 40, p, l);
    chk_in("narrow stopped", 0, 0, p[15:0]);
    chk_in("pin a port lows", 0, 0, l[15:0]);
    rd(8'h00);
    chk("narrow flag cleared", 8'h00, rv);
    wr(8'h0C, 8'h02);
    wr(8'h00, 8'hC2);
    gap(1'b0, 100, g);
    chk_in("single no reload", 100, 100, g[15:0]);
    rd(8'h00);
    chk("single stopped", 8'h62, rv);
    wr(8'h00, 8'h20);
  endtask

  task automatic t_wide();
    i_port_b_data <= 1'b1;
    wr(8'h1C, 8'h05);
    wr(8'h20, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h08, {3'h4, k[1:0], 3'h3});
      gap(1'b1, 500, g);
      chk_in("wide period", 6 << k, 6 << k, g[15:0]);
      watch(1'b1, 12 << k, p, l);
      chk_in("wide irq count", 2, 2, p[15:0]);
      chk_in("pin b timer lows", 6 << k, 6 << k, l[15:0]);
      rd(8'h08);
      chk("wide flag set", {3'h5, k[1:0], 3'h3}, rv);
      wr(8'h08, 8'h00);
      idle(8);
      wr(8'h08, 8'h20);
    end
    idle(8);
    watch(1'b1, 100, p, l);
    chk_in("wide stopped", 0, 0, p[15:0]);
    chk_in("pin b port lows", 0, 0, l[15:0]);
    rd(8'h08);
    chk("wide flag cleared", 8'h00, rv);
    wr(8'h08, 8'hC2);
    gap(1'b1, 100, g);
    chk_in("wide single", 100, 100, g[15:0]);
  endtask

  task automatic t_capture();
    wr(8'h0C, NARROW_RELOAD);
    wr(8'h10, NARROW_RELOAD);
    wr(8'h04, 8'hB0);
    wr(8'h00, 8'h86);
    i_demod_in <= 1'b1;
    idle(10);
    i_demod_in <= 1'b0;
    watch(1'b0, 4, p, l);
    chk_in("capture irq", 1, 1, p[15:0]);
    idle(16);
    i_demod_in <= 1'b1;
    idle(2);
    rd(8'h18);
    chk_in("fall capture", 8, 12, {8'h00, rv});
    rd(8'h14);
    chk_in("rise capture", 18, 22, {8'h00, rv});
    rd(8'h04);
    chk("edge flags", 8'hB3, rv);
    idle(300);
    rd(8'h00);
    chk("capture timeout", 8'hA6, rv);
    wr(8'h00, 8'h00);
    idle(8);
    wr(8'h04, 8'h03);
    wr(8'h00, 8'h20);
    idle(4);
    rd(8'h04);
    chk("edge flags cleared", 8'h00, rv);
  endtask

  task automatic t_wcapture();
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'hFF);
    wr(8'h04, 8'h50);
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h08, m ? 8'hC4 : 8'h84);
      i_demod_in <= 1'b0;
      idle(4);
      i_demod_in <= 1'b1;
      watch(1'b1, 4, p, l);
      chk_in("wide capture irq", 1, 1, p[15:0]);
      rd(8'h24);
      chk_in("wide capture low", 4, 6, {8'h00, rv});
      rd(8'h28);
      chk("wide capture high", 8'h00, rv);
      i_demod_in <= 1'b0;
      idle(4);
      i_demod_in <= 1'b1;
      watch(1'b1, 4, p, l);
      chk_in("wide later edge", 1 - m, 1 - m, p[15:0]);
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs();
    t_narrow();
    t_wide();
    t_capture();
    t_wcapture();
    stop_test();
  end

  // runs take under two thousand cycles; far beyond that means a hang
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    $display("CHECK FAILED watchdog expected done seen hang");
    stop_test();
  end
endmodule
